// ### rtl/sched_pkg.sv
// Shared types, register map and encodings of the weekly schedule switch
package sched_pkg;
	localparam int SLOT_COUNT = 3;
	localparam int DAY_COUNT = 7;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Time of day; set low means no switching time
	typedef struct packed {
		logic set;
		logic [4:0] hour;
		logic [5:0] minute;
	} clock_time_s;

	// Current weekday (0 = Monday .. 6 = Sunday) and time
	typedef struct packed {
		logic [2:0] weekday;
		logic [4:0] hour;
		logic [5:0] minute;
	} rtc_now_s;

	// One schedule slot; days bit 0 = Monday .. bit 6 = Sunday
	typedef struct packed {
		logic [6:0] days;
		clock_time_s on_time;
		clock_time_s off_time;
	} slot_cfg_s;

	typedef enum logic [2:0] {
		OUT_IDLE = 3'b001,
		OUT_HELD = 3'b010,
		OUT_PULSE = 3'b100
	} out_state_e;

	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [1:0] SLOT_FIRST = 2'h1;
	localparam logic [1:0] FIELD_DAYS = 2'h0;
	localparam logic [1:0] FIELD_ON = 2'h1;
	localparam logic [1:0] FIELD_OFF = 2'h2;
	localparam int CTRL_PULSE_BIT = 0;
	localparam int STATUS_OUT_BIT = 0;
	localparam int STATUS_PULSE_BIT = 1;
	localparam int TIME_W = 12;
	localparam logic [2:0] WEEKDAY_LAST = 3'h6;
	localparam logic PULSE_RESET = 1'b0;
	localparam slot_cfg_s SLOT_RESET = '0;

	// Slot number addressed, or SLOT_COUNT when not a slot register
	function automatic logic [1:0] slot_of(input logic [3:0] addr);
		if (addr[3:2] >= SLOT_FIRST
		    && {1'b0, addr[3:2]} < 3'(SLOT_FIRST + SLOT_COUNT)
		    && addr[1:0] != 2'h3) begin
			return addr[3:2] - SLOT_FIRST;
		end
		return 2'(SLOT_COUNT);
	endfunction
endpackage

// ### rtl/schedule_slot.sv
// One schedule slot: its stored settings and its on/off match
`timescale 1ns/1ps
module schedule_slot (
	input wire logic ref_clk, // Clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic wr_en, // Write to this slot
	input wire logic [1:0] field, // Field written
	input wire logic [sched_pkg::DATA_W-1:0] wr_data, // Write data
	input wire sched_pkg::rtc_now_s now, // Current weekday and time
	output sched_pkg::slot_cfg_s cfg, // Stored settings
	output logic on_hit, // Now matches on-time
	output logic off_hit // Now matches off-time
);
	import sched_pkg::*;

	slot_cfg_s next_cfg;
	logic day_ok;

	always_comb begin
		next_cfg = cfg;
		if (wr_en) begin
			unique case (field)
				FIELD_DAYS: next_cfg.days = wr_data[DAY_COUNT-1:0];
				FIELD_ON: next_cfg.on_time = wr_data[TIME_W-1:0];
				FIELD_OFF: next_cfg.off_time = wr_data[TIME_W-1:0];
				default: next_cfg = cfg;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cfg <= SLOT_RESET;
		end else begin
			cfg <= next_cfg;
		end
	end

	always_comb begin
		day_ok = (now.weekday <= WEEKDAY_LAST)
			&& cfg.days[now.weekday];
		on_hit = day_ok && cfg.on_time.set
			&& cfg.on_time.hour == now.hour
			&& cfg.on_time.minute == now.minute;
		off_hit = day_ok && cfg.off_time.set
			&& cfg.off_time.hour == now.hour
			&& cfg.off_time.minute == now.minute;
	end

	default clocking chk_clk @(posedge ref_clk);
	endclocking

	default disable iff (sys_rst);

	unset_on_a: assert property (
		!cfg.on_time.set |-> !on_hit)
		else $error("on match from unset on-time");
	unset_off_a: assert property (
		!cfg.off_time.set |-> !off_hit)
		else $error("off match from unset off-time");
	day_gate_a: assert property (
		(on_hit || off_hit) |-> cfg.days[now.weekday])
		else $error("match on unselected weekday");
	on_time_a: assert property (
		on_hit |-> {now.hour, now.minute} == {cfg.on_time.hour,
		cfg.on_time.minute})
		else $error("on match at wrong time");
endmodule

// ### rtl/weekly_schedule_switch.sv
// Weekly schedule switch: three slots drive one output from weekday/time
// What this block does
// - Three slots, each with days, on-time, off-time, drive one output.
// - Output set at a slot on-time; cleared at off-time or after pulse.
// - Pulse mode: output high until the next evaluation without an on-event.
// - One pulse setting shared by all three slots.
// - Overlaps: earliest on-event and earliest off-event win.
// - Output comes from combined state of all slots.
// - Times held as hour and minute, 00:00 through 23:59.
// - An unset time never causes a switching event.
// - Seven-day mask Monday..Sunday; slot acts only on selected days.
`timescale 1ns/1ps
module weekly_schedule_switch (
	input wire logic ref_clk, // 200 MHz clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic [sched_pkg::ADDR_W-1:0] addr, // Register address
	input wire logic [sched_pkg::DATA_W-1:0] wr_data, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [sched_pkg::DATA_W-1:0] rd_data, // Read data, next cycle
	input wire sched_pkg::rtc_now_s now, // Weekday and time from clock
	input wire logic eval_tick, // Evaluation cycle strobe
	output logic sw_out // Switch output
);
	import sched_pkg::*;

	slot_cfg_s cfg [SLOT_COUNT];
	logic [SLOT_COUNT-1:0] on_hits;
	logic [SLOT_COUNT-1:0] off_hits;
	logic [1:0] wr_slot;
	logic [1:0] rd_slot;

	// Slot storage and matching
	genvar gi;
	generate
		for (gi = 0; gi < SLOT_COUNT; gi++) begin : g_slot
			schedule_slot u_slot (
				.ref_clk(ref_clk),
				.sys_rst(sys_rst),
				.wr_en(wr_en && wr_slot == 2'(gi)),
				.field(addr[1:0]),
				.wr_data(wr_data),
				.now(now),
				.cfg(cfg[gi]),
				.on_hit(on_hits[gi]),
				.off_hit(off_hits[gi])
			);
		end
	endgenerate

	assign wr_slot = slot_of(addr);
	assign rd_slot = slot_of(addr);

	// Control register
	logic pulse_mode;
	logic next_pulse_mode;

	always_comb begin
		next_pulse_mode = pulse_mode;
		if (wr_en && addr == ADDR_CTRL) begin
			next_pulse_mode = wr_data[CTRL_PULSE_BIT];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pulse_mode <= PULSE_RESET;
		end else begin
			pulse_mode <= next_pulse_mode;
		end
	end

	// Minute stamp, so one minute's events apply only once
	rtc_now_s last_now;
	logic stamp_valid;
	rtc_now_s next_last_now;
	logic next_stamp_valid;
	logic new_minute;
	logic on_any;
	logic off_any;

	always_comb begin
		new_minute = !stamp_valid || now != last_now;
		next_last_now = last_now;
		next_stamp_valid = stamp_valid;
		if (eval_tick) begin
			next_last_now = now;
			next_stamp_valid = 1'b1;
		end
		on_any = eval_tick && new_minute && (|on_hits);
		off_any = eval_tick && new_minute && (|off_hits);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			last_now <= '0;
			stamp_valid <= 1'b0;
		end else begin
			last_now <= next_last_now;
			stamp_valid <= next_stamp_valid;
		end
	end

	// Output state; on-event beats off-event in the same minute
	out_state_e state;
	out_state_e next_state;
	logic next_sw_out;

	always_comb begin
		next_state = state;
		if (eval_tick) begin
			unique case (state)
				OUT_IDLE: begin
					if (on_any) begin
						next_state = pulse_mode ? OUT_PULSE : OUT_HELD;
					end
				end
				OUT_HELD: begin
					if (on_any && pulse_mode) begin
						next_state = OUT_PULSE;
					end else if (off_any && !on_any) begin
						next_state = OUT_IDLE;
					end
				end
				OUT_PULSE: begin
					if (on_any) begin
						next_state = pulse_mode ? OUT_PULSE : OUT_HELD;
					end else begin
						next_state = OUT_IDLE;
					end
				end
				default: next_state = OUT_IDLE;
			endcase
		end
		next_sw_out = next_state != OUT_IDLE;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state <= OUT_IDLE;
			sw_out <= 1'b0;
		end else begin
			state <= next_state;
			sw_out <= next_sw_out;
		end
	end

	// Register read, answered one cycle after the strobe
	logic [DATA_W-1:0] next_rd_data;

	always_comb begin
		next_rd_data = '0;
		if (rd_en) begin
			if (addr == ADDR_CTRL) begin
				next_rd_data[CTRL_PULSE_BIT] = pulse_mode;
			end else if (addr == ADDR_STATUS) begin
				next_rd_data[STATUS_OUT_BIT] = sw_out;
				next_rd_data[STATUS_PULSE_BIT] = state == OUT_PULSE;
			end else if (rd_slot < 2'(SLOT_COUNT)) begin
				unique case (addr[1:0])
					FIELD_DAYS: next_rd_data[DAY_COUNT-1:0] = cfg[rd_slot].days;
					FIELD_ON: next_rd_data[TIME_W-1:0] = cfg[rd_slot].on_time;
					FIELD_OFF: next_rd_data[TIME_W-1:0] = cfg[rd_slot].off_time;
					default: next_rd_data = '0;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_data <= '0;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// Checks
	default clocking chk_clk @(posedge ref_clk);
	endclocking

	default disable iff (sys_rst);

	// Helper: quiet evaluations seen while a pulse stands
	logic [1:0] pulse_age;
	logic [1:0] next_pulse_age;

	always_comb begin
		next_pulse_age = pulse_age;
		if (state != OUT_PULSE) begin
			next_pulse_age = 2'h0;
		end else if (eval_tick && !on_any && pulse_age != 2'h3) begin
			next_pulse_age = pulse_age + 2'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pulse_age <= 2'h0;
		end else begin
			pulse_age <= next_pulse_age;
		end
	end

	sequence pulse_fire;
		eval_tick && pulse_mode && on_any;
	endsequence

	sequence quiet_tick;
		eval_tick && !on_any && state == OUT_PULSE;
	endsequence

	sequence held_on;
		eval_tick && !pulse_mode && on_any;
	endsequence

	sequence held_quiet;
		eval_tick && !on_any && !off_any && state == OUT_HELD;
	endsequence

	sequence stale_tick;
		eval_tick && !new_minute;
	endsequence

	sequence status_read;
		rd_en && addr == ADDR_STATUS;
	endsequence

	sequence ctrl_read;
		rd_en && addr == ADDR_CTRL;
	endsequence

	sequence ctrl_write;
		wr_en && addr == ADDR_CTRL;
	endsequence

	on_set_a: assert property (
		on_any |=> sw_out)
		else $error("on-event did not set output");

	off_clear_a: assert property (
		(off_any && !on_any) |=> !sw_out)
		else $error("off-event did not clear output");

	pulse_len_a: assert property (
		quiet_tick |=> !sw_out)
		else $error("pulse lasted beyond one evaluation");

	pulse_hold_a: assert property (
		pulse_fire ##1 !eval_tick |-> sw_out)
		else $error("pulse dropped before next evaluation");

	pulse_age_a: assert property (
		(pulse_age != 2'h0) |-> (state == OUT_IDLE && !sw_out))
		else $error("pulse survived a quiet evaluation");

	pulse_all_a: assert property (
		(eval_tick && pulse_mode && new_minute
		&& (|(on_hits & ~(on_hits - 3'h1)))) |=> state == OUT_PULSE)
		else $error("pulse setting not applied to slot");

	any_slot_a: assert property (
		(eval_tick && new_minute && (|on_hits)) |=> sw_out)
		else $error("slot on-event ignored");

	out_state_a: assert property (
		sw_out == (state != OUT_IDLE))
		else $error("output disagrees with state");

	held_mode_a: assert property (
		held_on |=> state == OUT_HELD)
		else $error("held on-event did not latch");

	held_stay_a: assert property (
		held_quiet |=> sw_out)
		else $error("held output dropped without off-event");

	hold_a: assert property (
		!eval_tick |=> $stable(sw_out))
		else $error("output changed outside evaluation");

	once_min_a: assert property (
		(eval_tick && !new_minute && state != OUT_PULSE) |=> $stable(sw_out))
		else $error("same minute applied twice");

	stale_a: assert property (
		stale_tick |-> (!on_any && !off_any))
		else $error("event taken in a repeated minute");

	stamp_a: assert property (
		eval_tick |=> (stamp_valid && last_now == $past(now)))
		else $error("minute stamp not taken at evaluation");

	status_rd_a: assert property (
		status_read |=> rd_data[STATUS_OUT_BIT] == $past(sw_out))
		else $error("status read does not show output");

	status_pulse_a: assert property (
		status_read |=> rd_data[STATUS_PULSE_BIT]
		== ($past(state) == OUT_PULSE))
		else $error("status read does not show pulse state");

	ctrl_rd_a: assert property (
		ctrl_read |=> rd_data[CTRL_PULSE_BIT] == $past(pulse_mode))
		else $error("control read does not show pulse setting");

	ctrl_wr_a: assert property (
		ctrl_write |=> pulse_mode == $past(wr_data[CTRL_PULSE_BIT]))
		else $error("pulse setting not written");

	rd_idle_a: assert property (
		!rd_en |=> rd_data == '0)
		else $error("read data present without read strobe");
endmodule

// ### sim/tb.sv
// Testbench of the weekly schedule switch: register access and evaluations
`timescale 1ns/1ps
module tb;
	import sched_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wr_data = '0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [DATA_W-1:0] rd_data;
	rtc_now_s now = '0;
	logic eval_tick = 1'b0;
	logic sw_out;
	int errors = 0;
	int n_checks = 0;

	weekly_schedule_switch dut (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.now(now),
		.eval_tick(eval_tick),
		.sw_out(sw_out)
	);

	always #2.5 ref_clk = ~ref_clk;

	task automatic summarize();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] v, input logic [15:0] e);
		n_checks++;
		if (v !== e) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, v, e);
		end
	endtask

	// Time word: set flag, hour, minute
	function automatic logic [15:0] tw(input int h, input int m);
		return {4'h0, 1'b1, 5'(h), 6'(m)};
	endfunction

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, e);
	endtask

	task automatic slot(input int k, input logic [6:0] d,
	    input logic [15:0] on_w, input logic [15:0] off_w);
		wr(4'(4 * k + 4), {9'h000, d});
		wr(4'(4 * k + 5), on_w);
		wr(4'(4 * k + 6), off_w);
	endtask

	// One evaluation; output settles at the edge after the tick
	task automatic ev(input int wd, input int h, input int m, input logic e);
		@(posedge ref_clk);
		now <= {3'(wd), 5'(h), 6'(m)};
		eval_tick <= 1'b1;
		@(posedge ref_clk);
		eval_tick <= 1'b0;
		#1;
		chk({15'h0000, sw_out}, {15'h0000, e});
		repeat (3) @(posedge ref_clk);
		#1;
		chk({15'h0000, sw_out}, {15'h0000, e});
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		summarize();
	end

	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			rd(4'(i), 16'h0000);
		end
		// Overlapping slots on Monday
		slot(0, 7'h01, tw(1, 0), tw(2, 0));
		slot(1, 7'h01, tw(1, 10), tw(1, 50));
		slot(2, 7'h01, tw(1, 20), tw(1, 40));
		rd(4'h5, tw(1, 0));
		rd(4'hE, tw(1, 40));
		ev(0, 0, 59, 1'b0);
		ev(0, 1, 0, 1'b1);
		ev(0, 1, 10, 1'b1);
		ev(0, 1, 20, 1'b1);
		rd(4'h1, 16'h0001);
		ev(0, 1, 40, 1'b0);
		ev(0, 1, 50, 1'b0);
		ev(0, 2, 0, 1'b0);
		// Day selection; a new minute before the retry
		ev(1, 1, 0, 1'b0);
		wr(4'h4, 16'h0042);
		ev(1, 0, 59, 1'b0);
		ev(1, 1, 0, 1'b1);
		ev(1, 2, 0, 1'b0);
		ev(6, 1, 0, 1'b1);
		ev(6, 2, 0, 1'b0);
		wr(4'h4, 16'h007F);
		ev(7, 1, 0, 1'b0);
		// Unset on-time never switches
		slot(1, 7'h00, tw(1, 10), tw(1, 50));
		slot(2, 7'h00, tw(1, 20), tw(1, 40));
		wr(4'h5, 16'h0040);
		ev(2, 1, 0, 1'b0);
		// Day boundary across midnight
		slot(0, 7'h41, tw(23, 59), tw(0, 0));
		ev(6, 23, 58, 1'b0);
		ev(6, 23, 59, 1'b1);
		ev(0, 0, 0, 1'b0);
		// On and off in one evaluation: on wins
		slot(1, 7'h7F, tw(5, 0), tw(6, 0));
		slot(2, 7'h7F, tw(6, 0), tw(5, 0));
		ev(0, 5, 0, 1'b1);
		ev(0, 6, 0, 1'b1);
		ev(0, 6, 0, 1'b1);
		// Pulse mode applied to slots 2 and 0, entered while held
		wr(4'h0, 16'h0001);
		rd(4'h0, 16'h0001);
		slot(2, 7'h7F, tw(1, 20), tw(1, 21));
		ev(2, 1, 20, 1'b1);
		rd(4'h1, 16'h0003);
		ev(2, 1, 20, 1'b0);
		ev(2, 1, 21, 1'b0);
		ev(6, 23, 59, 1'b1);
		ev(0, 0, 1, 1'b0);
		rd(4'h1, 16'h0000);
		// Reset in mid-run clears all settings
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(4'h0, 16'h0000);
		rd(4'h5, 16'h0000);
		ev(6, 23, 59, 1'b0);
		summarize();
	end
endmodule
